// *** dv/fra_bench.sv ***
// bench joining the modem end and the host end over fra_link_if
// assumes fra_defs.svh on the include path, 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "fra_defs.svh"
module fra_bench;
    import fra_pkg::*;
    typedef struct {logic acq; logic crc; logic imp; logic [7:0] mids; logic bad;
                    logic [7:0] hdr;} fra_row_type;
    logic clk, rst, carrier_present, sync_seen, block_done, block_crc_ok, block_byte_vld;
    logic signed [7:0] rx_sample, peak_pos, peak_neg;
    logic [7:0]  block_byte, mid_blocks, rx_byte, cmd_q;
    logic [1:0]  level_mode, pll_mode;
    logic [15:0] crc_seed;
    logic        acquiring, m_shaping, m_carrier_ok, h_shaping, start, acquire, crc_form;
    logic        rx_byte_vld, frame_done, frame_error;
    logic [7:0]  exp_q[$];
    logic [7:0]  got_q[$];
    int          error_cnt = 0;
    int          num_checks = 0;
    fra_row_type rows [4] = '{'{1'b1, 1'b0, 1'b1, 8'h01, 1'b0, 8'h0A},
                              '{1'b0, 1'b1, 1'b0, 8'h02, 1'b0, 8'h0A},
                              '{1'b1, 1'b1, 1'b1, 8'h00, 1'b0, 8'h0A},
                              '{1'b0, 1'b0, 1'b0, 8'h01, 1'b1, 8'h0A}};
    fra_link_if link ();
    fra_modem i_fra_modem (.clk(clk), .rst(rst), .link(link), .carrier_present(carrier_present),
        .sync_seen(sync_seen), .rx_sample(rx_sample), .block_done(block_done),
        .block_crc_ok(block_crc_ok), .block_byte(block_byte), .block_byte_vld(block_byte_vld),
        .level_mode(level_mode), .pll_mode(pll_mode), .acquiring(acquiring), .crc_seed(crc_seed),
        .impulse_shaping(m_shaping), .peak_pos(peak_pos), .peak_neg(peak_neg),
        .carrier_ok(m_carrier_ok));
    fra_host i_fra_host (.clk(clk), .rst(rst), .link(link), .start(start), .acquire(acquire),
        .carrier_ok(m_carrier_ok), .mid_blocks(mid_blocks), .crc_form(crc_form),
        .impulse_shaping(h_shaping), .rx_byte(rx_byte), .rx_byte_vld(rx_byte_vld),
        .frame_done(frame_done), .frame_error(frame_error));
    fra_link_monitor i_fra_link_monitor (.clk(clk), .rst(rst), .cmd_wr(link.cmd_wr),
        .cmd_byte(link.cmd_byte), .level_response(link.level_response),
        .loop_bandwidth(link.loop_bandwidth), .interrupt_enable(link.interrupt_enable),
        .power_save(link.power_save), .eye_output(link.eye_output), .buf_rd(link.buf_rd),
        .stat_rd(link.stat_rd), .buf_data(link.buf_data), .irq_n(link.irq_n),
        .buffer_free(link.buffer_free), .check_fail_flag(link.check_fail_flag),
        .buffer_overflow_flag(link.buffer_overflow_flag));
    // ----------------
    // clock, samples, byte capture
    // ----------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) rx_sample <= -rx_sample;
    always @(posedge clk) if (rx_byte_vld === 1'b1) got_q.push_back(rx_byte);
    // ----------------
    // checks and waits
    // ----------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize
    task automatic chk_flag(input string name, input logic exp, input logic got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_flag
    task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_val
    task automatic fail(input string name);
        error_cnt++;
        $display("MISMATCH %s expected event seen none", name);
        summarize();
    endtask : fail
    task automatic wait_cmd();
        int i;
        for (i = 0; i < 4000 && link.cmd_wr !== 1'b1; i++) @(negedge clk);
        if (link.cmd_wr !== 1'b1) fail("command write");
        cmd_q = link.cmd_byte;
        repeat (2) @(negedge clk);
    endtask : wait_cmd
    task automatic feed(input logic [3:0] blk, input logic [7:0] n, input logic [7:0] cap,
                        input logic ok, input logic end_blk);
        int i;
        for (i = 0; i < n; i++) begin
            block_byte <= {blk, i[3:0]};
            block_byte_vld <= 1'b1;
            if (i < cap) exp_q.push_back({blk, i[3:0]});
            @(negedge clk);
        end
        block_byte_vld <= 1'b0;
        block_done <= 1'b1;
        block_crc_ok <= ok;
        @(negedge clk);
        block_done <= 1'b0;
        for (i = 0; i < 50 && link.irq_n !== 1'b0; i++) @(negedge clk);
        if (link.irq_n !== 1'b0) fail("interrupt");
        chk_flag("free at irq", 1'b1, link.buffer_free);
        chk_flag("overflow flag", n > cap, link.buffer_overflow_flag);
        if (end_blk) chk_flag("crc fail flag", !ok, link.check_fail_flag);
    endtask : feed
    task automatic run_frame(input fra_row_type r);
        int k;
        logic err;
        logic [7:0] last;
        logic [7:0] n;
        err = r.bad || r.hdr > 8'h0A;
        last = r.mids + 8'h01;
        exp_q.delete();
        got_q.delete();
        acquire <= r.acq;
        crc_form <= r.crc;
        h_shaping <= r.imp;
        mid_blocks <= r.mids;
        start <= 1'b1;
        @(negedge clk);
        start <= 1'b0;
        for (k = 0; k <= last; k++) begin
            wait_cmd();
            chk_flag("crc form bit", r.crc, cmd_q[5]);
            chk_flag("shaping bit", r.imp, cmd_q[4]);
            chk_val("trigger bits", (k == 0 && r.acq) ? 2'h3 : 2'h0, cmd_q[7:6]);
            chk_val("crc seed", r.crc ? 16'h0000 : 16'hFFFF, crc_seed);
            chk_flag("shaping out", r.imp, m_shaping);
            if (k == 0 && r.acq) begin
                chk_val("clamp start", LEV_CLAMP, level_mode);
                chk_val("xwide start", BW_XWIDE, pll_mode);
                chk_flag("acquiring", 1'b1, acquiring);
                repeat (`FRA_SYMBOL_CYC - 13) @(negedge clk);
                chk_val("clamp end", LEV_CLAMP, level_mode);
                repeat (22) @(negedge clk);
                chk_val("lossy", LEV_LOSSY, level_mode);
                chk_val("xwide held", BW_XWIDE, pll_mode);
                chk_flag("peak spread", 1'b1, peak_pos > peak_neg);
            end
            if (k == 0) begin
                sync_seen <= 1'b1;
                @(negedge clk);
                sync_seen <= 1'b0;
                repeat (2) @(negedge clk);
                chk_val("level after sync", LEV_TRACK, level_mode);
            end
            n = (k == 0) ? r.hdr : (k == last) ? 8'h08 : 8'h0C;
            feed(k[3:0], n, (k == 0) ? 8'h0A : n, !(r.bad && k == last), k == 0 || k == last);
            if (k == 0 && r.hdr > 8'h0A) break;
        end
        for (k = 0; k < 4000 && frame_done !== 1'b1 && !(frame_error === 1'b1 && r.hdr > 8'h0A);
             k++) @(negedge clk);
        if (frame_done !== 1'b1 && !(frame_error === 1'b1 && r.hdr > 8'h0A)) fail("frame end");
        @(negedge clk);
        chk_flag("frame error", err, frame_error);
        if (!err) begin
            chk_val("byte count", exp_q.size(), got_q.size());
            for (k = 0; k < exp_q.size() && k < got_q.size(); k++)
                chk_val("rx byte", exp_q[k], got_q[k]);
        end
    endtask : run_frame
    // ----------------
    // main sequence
    // ----------------
    initial begin
        rst = 1'b1;
        carrier_present = 1'b1;
        rx_sample = 8'sd90;
        {sync_seen, block_done, block_crc_ok, block_byte_vld} = 4'h0;
        block_byte = 8'h00;
        {start, acquire, crc_form, h_shaping} = 4'h0;
        mid_blocks = 8'h00;
        repeat (12) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        foreach (rows[j]) begin
            run_frame(rows[j]);
            $display("row %0d done", j);
        end
        run_frame('{1'b0, 1'b0, 1'b0, 8'h01, 1'b0, 8'h0B});
        $display("overflow test done");
        rst <= 1'b1;
        @(negedge clk);
        rst <= 1'b0;
        acquire <= 1'b1;
        start <= 1'b1;
        @(negedge clk);
        start <= 1'b0;
        wait_cmd();
        chk_flag("acquiring set", 1'b1, acquiring);
        rst <= 1'b1;
        repeat (3) @(negedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk_flag("irq_n reset", 1'b1, link.irq_n);
        chk_flag("free reset", 1'b1, link.buffer_free);
        chk_flag("overflow reset", 1'b0, link.buffer_overflow_flag);
        chk_val("level reset", LEV_TRACK, level_mode);
        chk_val("pll reset", BW_WIDE, pll_mode);
        chk_val("host bw reset", BW_WIDE, link.loop_bandwidth);
        chk_flag("acquiring reset", 1'b0, acquiring);
        $display("reset test done");
        summarize();
    end
endmodule : fra_bench
`default_nettype wire

// *** dv/fra_link_monitor.sv ***
// checker for the host to modem link signals
// assumes instantiation beside fra_link_if, one clock, rst sync high
`timescale 1ns/1ps
`default_nettype none
module fra_link_monitor
    import fra_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cmd_wr,
    input  wire logic [7:0] cmd_byte,
    input  wire logic [1:0] level_response,
    input  wire logic [1:0] loop_bandwidth,
    input  wire logic       interrupt_enable,
    input  wire logic       power_save,
    input  wire logic       eye_output,
    input  wire logic       buf_rd,
    input  wire logic       stat_rd,
    input  wire logic [7:0] buf_data,
    input  wire logic       irq_n,
    input  wire logic       buffer_free,
    input  wire logic       check_fail_flag,
    input  wire logic       buffer_overflow_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------
    // sequences
    // ----------------
    sequence acq_cmd_s;
        cmd_wr && cmd_byte[7:6] != 2'h0;
    endsequence
    sequence release_s;
        !irq_n ##1 irq_n;
    endsequence
    // ----------------
    // assertions
    // ----------------
    free_before_cmd_a: assert property (cmd_wr |-> buffer_free)
        else $error("command written while buffer busy");
    cmd_clears_free_a: assert property (cmd_wr && cmd_byte[3:0] != 4'h0 |=> !buffer_free)
        else $error("buffer free not cleared by task");
    irq_after_free_a: assert property ($rose(buffer_free) |=> !irq_n)
        else $error("no interrupt after task end");
    irq_holds_a: assert property (!irq_n && !stat_rd && !$past(stat_rd) |=> !irq_n)
        else $error("interrupt released without status read");
    irq_release_a: assert property (stat_rd && !irq_n |=> release_s)
        else $error("interrupt not released after status read");
    acq_setup_a: assert property (acq_cmd_s |-> loop_bandwidth == BW_WIDE
        && level_response == LEV_TRACK) else $error("acquisition without wide and track");
    acq_both_bits_a: assert property (acq_cmd_s |-> cmd_byte[7:6] == 2'h3
        && (cmd_byte[3:0] == 4'h1 || cmd_byte[3:0] == 4'h2)) else $error("bad acquire command");
    block_medium_a: assert property (cmd_wr && cmd_byte[3:0] == 4'h3 |->
        loop_bandwidth == BW_MEDIUM && cmd_byte[7:6] == 2'h0) else $error("block task not medium");
    later_frame_a: assert property (cmd_wr && cmd_byte == 8'h02 || cmd_wr && cmd_byte[7:6] == 2'h0
        && cmd_byte[3:0] == 4'h2 |-> loop_bandwidth == BW_MEDIUM && level_response == LEV_TRACK)
        else $error("later frame without medium and track");
    rx_mode_a: assert property (interrupt_enable && !power_save && !eye_output)
        else $error("receive mode bits wrong");
endmodule : fra_link_monitor
`default_nettype wire

// *** logic/fra_defs.svh ***
// constants for the fsk receive acquisition sequencer and its host end
// assumes inclusion by bare name from logic/ sources
`ifndef FRA_DEFS_SVH
`define FRA_DEFS_SVH
// ----------------------------------------------------------------
// symbol timing
// ----------------------------------------------------------------
`define FRA_CLK_MHZ          100
`define FRA_SYMBOL_US        208
`define FRA_SYMBOL_CYC       (`FRA_SYMBOL_US * `FRA_CLK_MHZ)
`define FRA_CLAMP_SYMS       8'h01
`define FRA_LOSSY_SYMS       8'h0F
`define FRA_XWIDE_SYMS       8'h10
`define FRA_CLK_ACQ_SYMS     8'h2D
`define FRA_CARRIER_SYMS     8'h08
// ----------------------------------------------------------------
// command byte fields
// ----------------------------------------------------------------
`define FRA_CMD_TASK_LSB     0
`define FRA_CMD_CLK_ACQ_BIT  6
`define FRA_CMD_LEV_ACQ_BIT  7
`define FRA_CMD_CRC_BIT      5
`define FRA_CMD_IMP_BIT      4
`define FRA_TASK_SYNC        4'h1
`define FRA_TASK_SYNC_HDR    4'h2
`define FRA_TASK_BLOCK       4'h3
// ----------------------------------------------------------------
// buffer byte counts, block and sync symbol counts, crc16 seeds
// ----------------------------------------------------------------
`define FRA_HDR_BYTES        4'hA
`define FRA_MID_BYTES        4'hC
`define FRA_LAST_BYTES       4'h8
`define FRA_BLOCK_SYMS       8'h42
`define FRA_SYNC_SYMS        8'h18
`define FRA_CRC16_ONES       16'hFFFF
`define FRA_CRC16_ZERO       16'h0000
`endif

// *** logic/fra_host.sv ***
// host end: runs the receive frame procedure against the modem
// assumes user supplies carrier qualification and block count
`timescale 1ns/1ps
`default_nettype none
`include "fra_defs.svh"
module fra_host
    import fra_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    fra_link_if.host         link,
    input  wire logic        start,
    input  wire logic        acquire,
    input  wire logic        carrier_ok,
    input  wire logic [7:0]  mid_blocks,
    input  wire logic        crc_form,
    input  wire logic        impulse_shaping,
    output logic [7:0]       rx_byte,
    output logic             rx_byte_vld,
    output logic             frame_done,
    output logic             frame_error
);
    typedef enum logic [2:0] {H_IDLE, H_WAIT_CAR, H_TASK, H_WAIT_IRQ, H_READ} fra_hstate_type;
    fra_hstate_type st_q;
    logic [7:0] blk_q;
    logic [3:0] cnt_q, need_q;
    logic       hdr_q, acq_q, cmd_wr_q, stat_q, rd_q, vld_q, done_q, err_q;
    logic [7:0] cmd_q, byte_q;
    logic [1:0] bw_q;
    logic [3:0] task_sel;
    assign task_sel = hdr_q ? `FRA_TASK_SYNC_HDR : `FRA_TASK_BLOCK;
    // ----------------------------------------------------------------
    // frame procedure
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= H_IDLE;
            blk_q <= 8'h00;
            cnt_q <= 4'h0;
            need_q <= 4'h0;
            hdr_q <= 1'b0;
            acq_q <= 1'b0;
            cmd_wr_q <= 1'b0;
            cmd_q <= 8'h00;
            stat_q <= 1'b0;
            rd_q <= 1'b0;
            vld_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            byte_q <= 8'h00;
            bw_q <= BW_WIDE;
        end else begin
            cmd_wr_q <= 1'b0;
            stat_q <= 1'b0;
            rd_q <= 1'b0;
            vld_q <= rd_q;
            byte_q <= link.buf_data;
            done_q <= 1'b0;
            case (st_q)
                H_IDLE: if (start) begin
                    hdr_q <= 1'b1;
                    acq_q <= acquire;
                    blk_q <= mid_blocks;
                    err_q <= 1'b0;
                    if (acquire) bw_q <= BW_WIDE;
                    st_q <= acquire ? H_WAIT_CAR : H_TASK;
                end
                H_WAIT_CAR: if (carrier_ok) st_q <= H_TASK;
                H_TASK: if (link.buffer_free) begin
                    cmd_wr_q <= 1'b1;
                    // acquisition bits only on the first task of a frame
                    cmd_q <= {acq_q, acq_q, crc_form, impulse_shaping, task_sel};
                    st_q <= H_WAIT_IRQ;
                end
                H_WAIT_IRQ: if (!link.irq_n && !stat_q) begin
                    stat_q <= 1'b1;
                    if (hdr_q) bw_q <= BW_MEDIUM;
                    // intermediate blocks carry no check code of their own
                    if (link.buffer_overflow_flag || ((hdr_q || blk_q == 8'h00)
                        && link.check_fail_flag)) err_q <= 1'b1;
                    need_q <= hdr_q ? `FRA_HDR_BYTES :
                              (blk_q == 8'h00) ? `FRA_LAST_BYTES : `FRA_MID_BYTES;
                    cnt_q <= 4'h0;
                    st_q <= H_READ;
                end
                H_READ: if (cnt_q == need_q) begin
                    hdr_q <= 1'b0;
                    acq_q <= 1'b0;
                    if (!hdr_q && need_q == `FRA_LAST_BYTES) begin
                        done_q <= 1'b1;
                        st_q <= H_IDLE;
                    end else begin
                        if (!hdr_q) blk_q <= blk_q - 8'h01;
                        st_q <= H_TASK;
                    end
                end else if (!rd_q) begin
                    rd_q <= 1'b1;
                    cnt_q <= cnt_q + 4'h1;
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
    // ----------------------------------------------------------------
    // link drive
    // ----------------------------------------------------------------
    assign link.cmd_wr           = cmd_wr_q;
    assign link.cmd_byte         = cmd_q;
    assign link.level_response   = LEV_TRACK;
    assign link.loop_bandwidth   = bw_q;
    assign link.interrupt_enable = 1'b1;
    assign link.power_save       = 1'b0;
    assign link.eye_output       = 1'b0;
    assign link.buf_rd           = rd_q;
    assign link.stat_rd          = stat_q;
    assign rx_byte     = byte_q;
    assign rx_byte_vld = vld_q;
    assign frame_done  = done_q;
    assign frame_error = err_q;
endmodule : fra_host
`default_nettype wire

// *** logic/fra_link_if.sv ***
// link between the modem acquisition end and the host end
// assumes a single clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface fra_link_if;
    logic       cmd_wr;
    logic [7:0] cmd_byte;
    logic [1:0] level_response;
    logic [1:0] loop_bandwidth;
    logic       interrupt_enable;
    logic       power_save;
    logic       eye_output;
    logic       buf_rd;
    logic       stat_rd;
    logic [7:0] buf_data;
    logic       irq_n;
    logic       buffer_free;
    logic       check_fail_flag;
    logic       buffer_overflow_flag;
    modport dev  (input cmd_wr, cmd_byte, level_response, loop_bandwidth, interrupt_enable,
                  power_save, eye_output, buf_rd, stat_rd,
                  output buf_data, irq_n, buffer_free, check_fail_flag, buffer_overflow_flag);
    modport host (output cmd_wr, cmd_byte, level_response, loop_bandwidth, interrupt_enable,
                  power_save, eye_output, buf_rd, stat_rd,
                  input buf_data, irq_n, buffer_free, check_fail_flag, buffer_overflow_flag);
endinterface : fra_link_if
`default_nettype wire

// *** logic/fra_modem.sv ***
// modem end: acquisition sequencing and frame receive handshake
// assumes decoded symbols and sync detection come from the demodulator
`timescale 1ns/1ps
`default_nettype none
`include "fra_defs.svh"
module fra_modem
    import fra_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    fra_link_if.dev          link,
    input  wire logic        carrier_present,
    input  wire logic        sync_seen,
    input  wire logic signed [7:0] rx_sample,
    input  wire logic        block_done,
    input  wire logic        block_crc_ok,
    input  wire logic [7:0]  block_byte,
    input  wire logic        block_byte_vld,
    output logic [1:0]       level_mode,
    output logic [1:0]       pll_mode,
    output logic             acquiring,
    output logic [15:0]      crc_seed,
    output logic             impulse_shaping,
    output logic signed [7:0] peak_pos,
    output logic signed [7:0] peak_neg,
    output logic             carrier_ok
);
    typedef enum logic [1:0] {T_IDLE, T_SYNC, T_HDR, T_BLOCK} fra_task_type;
    logic [15:0]     sym_cnt_q;
    logic            sym_tick;
    fra_level_type   lev_q, lev_d;
    fra_bw_type      bw_q;
    logic [7:0]      lev_cnt_q, clk_cnt_q;
    logic            lev_acq_q, clk_acq_q;
    fra_task_type    task_q;
    logic [7:0]      buf_mem [0:15];
    logic [3:0]      wr_ptr_q, rd_ptr_q, fill_q;
    logic            pend_q, free_q, fail_q, ovf_q, irq_n_q;
    logic signed [7:0] filt_q, pos_q, neg_q;
    logic [7:0]      car_cnt_q;
    logic            crc_form_q, imp_q;
    logic [3:0]      task_code;
    logic            start_acq, start_lev, start_clk, is_hdr;
    function automatic logic [7:0] inc_sat(input logic [7:0] v);
        inc_sat = (v == 8'hFF) ? v : v + 8'h01;
    endfunction : inc_sat
    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    assign sym_tick   = (sym_cnt_q == 16'(`FRA_SYMBOL_CYC - 1));
    assign task_code  = link.cmd_byte[`FRA_CMD_TASK_LSB +: 4];
    assign start_acq  = link.cmd_wr && (task_code != 4'h0);
    assign start_lev  = start_acq && link.cmd_byte[`FRA_CMD_LEV_ACQ_BIT];
    assign start_clk  = start_acq && link.cmd_byte[`FRA_CMD_CLK_ACQ_BIT];
    assign is_hdr     = (task_q == T_HDR);
    always_ff @(posedge clk) begin
        if (rst) sym_cnt_q <= 16'h0000;
        // acquisition restarts the symbol phase so clamp spans a full symbol
        else sym_cnt_q <= (sym_tick || start_lev || start_clk) ? 16'h0000 : sym_cnt_q + 16'h0001;
    end
    // ----------------------------------------------------------------
    // level acquisition
    // ----------------------------------------------------------------
    // sequence runs regardless of where in the frame it started
    always_comb begin
        lev_d = lev_q;
        if (!lev_acq_q) lev_d = fra_level_type'(link.level_response);
        else if (sync_seen) lev_d = fra_level_type'(link.level_response);
        else if (sym_tick && lev_q == LEV_CLAMP && lev_cnt_q + 8'h01 >= `FRA_CLAMP_SYMS)
            lev_d = LEV_LOSSY;
        else if (sym_tick && lev_q == LEV_LOSSY && lev_cnt_q + 8'h01 >= `FRA_LOSSY_SYMS)
            lev_d = LEV_SLOW;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            lev_q     <= LEV_TRACK;
            lev_acq_q <= 1'b0;
            lev_cnt_q <= 8'h00;
        end else if (start_lev) begin
            lev_q     <= LEV_CLAMP;
            lev_acq_q <= 1'b1;
            lev_cnt_q <= 8'h00;
        end else begin
            lev_q     <= lev_d;
            lev_acq_q <= lev_acq_q && !sync_seen;
            lev_cnt_q <= (lev_d != lev_q) ? 8'h00 : (sym_tick ? inc_sat(lev_cnt_q) : lev_cnt_q);
        end
    end
    // ----------------------------------------------------------------
    // clock acquisition
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            clk_acq_q <= 1'b0;
            clk_cnt_q <= 8'h00;
            bw_q      <= BW_MEDIUM;
        end else if (start_clk) begin
            clk_acq_q <= 1'b1;
            clk_cnt_q <= 8'h00;
            bw_q      <= BW_XWIDE;
        end else if (clk_acq_q) begin
            if (sym_tick) clk_cnt_q <= inc_sat(clk_cnt_q);
            if (sym_tick && clk_cnt_q + 8'h01 >= `FRA_CLK_ACQ_SYMS) begin
                clk_acq_q <= 1'b0;
                bw_q      <= fra_bw_type'(link.loop_bandwidth);
            end else if (sym_tick && clk_cnt_q + 8'h01 >= `FRA_XWIDE_SYMS) bw_q <= BW_WIDE;
        end else begin
            // outside acquisition field code 3 is not passed through: it would mean extra wide
            bw_q <= (link.loop_bandwidth == 2'b11) ? BW_WIDE : fra_bw_type'(link.loop_bandwidth);
        end
    end
    // ----------------------------------------------------------------
    // peak detection with low pass filter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            filt_q <= 8'sh00;
            pos_q  <= 8'sh00;
            neg_q  <= 8'sh00;
        end else begin
            // difference taken one bit wider so a full-scale swing cannot wrap
            filt_q <= 8'(filt_q + ((9'(rx_sample) - 9'(filt_q)) >>> 2));
            if (lev_q == LEV_CLAMP) begin
                pos_q <= rx_sample;
                neg_q <= rx_sample;
            end else if (lev_q == LEV_LOSSY || lev_q == LEV_SLOW) begin
                if (filt_q > pos_q) pos_q <= filt_q;
                if (filt_q < neg_q) neg_q <= filt_q;
            end
        end
    end
    // ----------------------------------------------------------------
    // receive tasks and buffer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            task_q <= T_IDLE;
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            fill_q <= 4'h0;
            pend_q <= 1'b0;
            free_q <= 1'b1;
            fail_q <= 1'b0;
            ovf_q  <= 1'b0;
            crc_form_q <= 1'b0;
            imp_q  <= 1'b0;
        end else begin
            if (link.cmd_wr) begin
                crc_form_q <= link.cmd_byte[`FRA_CMD_CRC_BIT];
                imp_q      <= link.cmd_byte[`FRA_CMD_IMP_BIT];
                free_q     <= 1'b0;
                wr_ptr_q   <= 4'h0;
                rd_ptr_q   <= 4'h0;
                fill_q     <= 4'h0;
                task_q     <= (task_code == `FRA_TASK_SYNC) ? T_SYNC :
                              (task_code == `FRA_TASK_SYNC_HDR) ? T_HDR :
                              (task_code == `FRA_TASK_BLOCK) ? T_BLOCK : T_IDLE;
            end else begin
                if (block_byte_vld && task_q != T_IDLE) begin
                    if (fill_q == (is_hdr ? `FRA_HDR_BYTES : `FRA_MID_BYTES)) ovf_q <= 1'b1;
                    else begin
                        buf_mem[wr_ptr_q] <= block_byte;
                        wr_ptr_q <= wr_ptr_q + 4'h1;
                        fill_q   <= fill_q + 4'h1;
                    end
                end
                if ((task_q == T_SYNC && sync_seen) || (task_q != T_SYNC && task_q != T_IDLE
                    && block_done)) begin
                    task_q <= T_IDLE;
                    free_q <= 1'b1;
                    fail_q <= (task_q != T_SYNC) && !block_crc_ok;
                    if (link.interrupt_enable) pend_q <= 1'b1;
                end
                if (link.buf_rd && rd_ptr_q != wr_ptr_q) rd_ptr_q <= rd_ptr_q + 4'h1;
                // a new event in the same cycle beats the status read
                if (link.stat_rd && !(block_done || sync_seen)) begin
                    pend_q <= 1'b0;
                    ovf_q  <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_n_q <= 1'b1;
            car_cnt_q <= 8'h00;
        end else begin
            irq_n_q <= !(pend_q && link.interrupt_enable);
            car_cnt_q <= carrier_present ? inc_sat(car_cnt_q) : 8'h00;
        end
    end
    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign link.buf_data             = buf_mem[rd_ptr_q];
    assign link.irq_n                = irq_n_q;
    assign link.buffer_free          = free_q;
    assign link.check_fail_flag      = fail_q;
    assign link.buffer_overflow_flag = ovf_q;
    assign level_mode      = lev_q;
    assign pll_mode        = bw_q;
    assign acquiring       = lev_acq_q | clk_acq_q;
    assign crc_seed        = crc_form_q ? `FRA_CRC16_ZERO : `FRA_CRC16_ONES;
    assign impulse_shaping = imp_q;
    assign peak_pos        = pos_q;
    assign peak_neg        = neg_q;
    assign carrier_ok      = (car_cnt_q >= `FRA_CARRIER_SYMS);
endmodule : fra_modem
`default_nettype wire

// *** logic/fra_pkg.sv ***
// types shared by both ends of the acquisition link
// assumes fra_defs.svh is on the include path
package fra_pkg;
    typedef enum logic [1:0] {LEV_TRACK, LEV_CLAMP, LEV_LOSSY, LEV_SLOW} fra_level_type;
    typedef enum logic [1:0] {BW_MEDIUM, BW_WIDE, BW_NARROW, BW_XWIDE} fra_bw_type;
endpackage : fra_pkg
